// file: tach_pkg.sv
package tach_pkg;

	// register byte addresses on the bus
	localparam logic [3:0] ADDR_INTERVAL_LIMIT   = 4'h0;
	localparam logic [3:0] ADDR_INTERVAL_READING = 4'h4;
	localparam logic [3:0] ADDR_TACH_CTRL_STATUS = 4'h8;
	localparam logic [3:0] ADDR_MONITOR_ENABLE   = 4'hC;

	// control/status field positions
	localparam int BIT_NEW_READING  = 0;
	localparam int BIT_SLOW_FAN     = 1;
	localparam int BIT_WRAP         = 2;
	localparam int BIT_ALERT_EN     = 3;
	localparam int BIT_FILTER_BYP   = 4;
	localparam int BIT_RATE_LO      = 5;

	// reset values
	localparam logic [7:0] RST_INTERVAL_LIMIT = 8'hFF;
	localparam logic [1:0] RST_COUNT_RATE     = 2'h1;

	// count-rate encoding
	localparam logic [1:0] RATE_16K = 2'h0;
	localparam logic [1:0] RATE_8K  = 2'h1;
	localparam logic [1:0] RATE_4K  = 2'h2;
	localparam logic [1:0] RATE_2K  = 2'h3;

	// timing
	localparam int CLK_HZ          = 25000000;
	localparam int FILTER_HZ       = 32000;
	localparam int MIN_PULSE_US    = 750;
	// filter clock ticks a pulse must last, rounded up
	localparam int FILTER_TICKS    = (MIN_PULSE_US * FILTER_HZ + 999999) / 1000000;
	localparam logic [4:0] FILTER_TICKS_C = 5'(FILTER_TICKS);

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [3:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [3:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_s;

	typedef struct packed {
		logic       enable;
		logic [1:0] count_rate;
		logic       filter_bypass;
		logic       alert_en;
		logic       wrap;
		logic       slow_fan;
		logic       new_reading;
	} ctrl_s;

endpackage : tach_pkg

// file: tach_sync.sv
`timescale 1ns/1ps
module tach_sync (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// async level in, synced level out
	input  wire logic d,
	output logic      q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sync_s;

	sync_s st_reg;
	sync_s st_next;

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule : tach_sync

// file: tach_glitch_filter.sv
`timescale 1ns/1ps
module tach_glitch_filter
	import tach_pkg::*;
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// synced tach level and filter clock tick
	input  wire logic din,
	input  wire logic tick,
	// filtered level
	output logic      dout
);
	typedef struct packed {
		logic       level;
		logic [4:0] cnt;
	} filt_s;

	filt_s st_reg;
	filt_s st_next;

	// level changes only after holding for the minimum pulse width
	always_comb begin
		st_next = st_reg;
		if (din == st_reg.level) begin
			st_next.cnt = '0;
		end else if (tick) begin
			if (st_reg.cnt + 5'h1 >= FILTER_TICKS_C) begin
				st_next.level = din;
				st_next.cnt   = '0;
			end else begin
				st_next.cnt = st_reg.cnt + 5'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.level;
endmodule : tach_glitch_filter

// file: fan_tach_period_monitor.sv
// Behaviour
// R01: 8-bit up counter measures interval; four 8-bit registers: reading, limit, control/status, monitor enable.
// R02: while disabled or after reset, counter and reading are zero.
// R03: enabled and no wrap: counter steps once per selected count clock cycle.
// R04: from second rising edge, load reading, zero counter, set new-reading.
// R05: reading the interval reading register clears new-reading.
// R06: loaded value above limit sets slow-fan flag and alert if enabled.
// R07: slow-fan set blocks reloads until cleared by one-write then a reading read.
// R08: counter passing FFh sets wrap, clears reading, alert if enabled.
// R09: software writes one to clear wrap; measurement then resumes.
// R10: bypass bit 4 zero: 32 KHz filter rejects pulses under 750 us.
// R11: two-bit rate field picks count clock 2, 4, 8 or 16 KHz.
// R12: limit register holds largest allowed interval, resets to FFh.
// R13: software should not change the limit while enabled.
// R14: write-one clears a status bit; write-zero leaves it.
// R15: control/status resets with rate 01, all other bits zero.
// R16: rate encoding 00 16 KHz, 01 8 KHz, 10 4 KHz, 11 2 KHz.
// R17: alert enabled raises alert when slow-fan or wrap is set.
// R18: new-reading clears when wrap becomes set.
// R19: tach input synchronised before the filter; rising edges found from synced samples.
// R20: after wrap counter holds until wrap cleared, then restarts from zero.
`timescale 1ns/1ps
module fan_tach_period_monitor
	import tach_pkg::*;
(
	// clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// register bus
	input  wire tach_pkg::axi_req_s axi_req,
	output tach_pkg::axi_rsp_s      axi_rsp,
	// count clocks and filter clock, from outside
	input  wire logic            clk_16k,
	input  wire logic            clk_8k,
	input  wire logic            clk_4k,
	input  wire logic            clk_2k,
	input  wire logic            clk_32k,
	// fan side
	input  wire logic            tach_pulse_in,
	output logic                 alert
);
	typedef struct packed {
		tach_pkg::axi_rsp_s rsp;
		logic               aw_held;
		logic [3:0]         aw_addr;
		logic               w_held;
		logic [31:0]        w_data;
		logic [3:0]         w_strb;
		tach_pkg::ctrl_s    ctrl;
		logic [7:0]         interval_limit;
		logic [7:0]         interval_reading;
		logic [7:0]         pulse_interval_count;
		logic               edges_seen;
		logic               read_pending;
		logic               tach_prev;
		logic               rate_prev;
		logic               flt_prev;
		logic               alert;
	} mon_s;

	mon_s st_reg;
	mon_s st_next;

	logic tach_sync_q;
	logic tach_filt_q;
	logic tach_use_q;
	logic c16_q;
	logic c8_q;
	logic c4_q;
	logic c2_q;
	logic c32_q;
	logic rate_lvl;
	logic rate_tick;
	logic flt_tick;
	logic tach_rise;
	logic wr_go;
	logic rd_go;
	logic [7:0] rd_byte;
	logic [1:0] rd_resp;
	logic [1:0] wr_resp;
	logic [7:0] wb;
	logic meas_on;
	logic edge_ok;
	logic tick_ok;
	logic load_ok;
	logic over_limit;
	logic wrap_hit;
	logic [7:0] cnt_start;
	logic ctrl_wr;
	logic wrap_clr;
	logic slow_clr;
	logic reading_rd;

	// pin and clock inputs through two flops
	tach_sync u_sync_tach (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (tach_pulse_in),
		.q       (tach_sync_q)
	); // [R19]
	tach_sync u_sync_16k (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (clk_16k),
		.q       (c16_q)
	);
	tach_sync u_sync_8k (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (clk_8k),
		.q       (c8_q)
	);
	tach_sync u_sync_4k (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (clk_4k),
		.q       (c4_q)
	);
	tach_sync u_sync_2k (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (clk_2k),
		.q       (c2_q)
	);
	tach_sync u_sync_32k (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (clk_32k),
		.q       (c32_q)
	);

	tach_glitch_filter u_filter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (tach_sync_q),
		.tick    (flt_tick),
		.dout    (tach_filt_q)
	); // [R10]

	always_comb begin
		case (st_reg.ctrl.count_rate) // [R11] [R16]
			RATE_16K: rate_lvl = c16_q;
			RATE_8K:  rate_lvl = c8_q;
			RATE_4K:  rate_lvl = c4_q;
			RATE_2K:  rate_lvl = c2_q;
			default:  rate_lvl = c8_q;
		endcase
	end

	assign rate_tick  = rate_lvl & ~st_reg.rate_prev;
	assign flt_tick   = c32_q & ~st_reg.flt_prev;
	assign tach_use_q = st_reg.ctrl.filter_bypass ? tach_sync_q : tach_filt_q; // [R10]
	assign tach_rise  = tach_use_q & ~st_reg.tach_prev; // [R19]

	// bus handshakes
	assign wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.rsp.bvalid;
	assign rd_go = axi_req.arvalid && st_reg.rsp.arready;
	assign wb    = st_reg.w_data[7:0];

	// measurement events; edges and ticks ignored while wrapped
	assign meas_on    = st_reg.ctrl.enable && !st_reg.ctrl.wrap; // [R20]
	assign edge_ok    = meas_on && tach_rise;
	assign tick_ok    = meas_on && rate_tick; // [R03]
	assign load_ok    = edge_ok && st_reg.edges_seen && !st_reg.ctrl.slow_fan
		&& !st_reg.read_pending; // [R04] [R07]
	assign over_limit = st_reg.pulse_interval_count > st_reg.interval_limit; // [R06]
	assign wrap_hit   = tick_ok && !tach_rise && (st_reg.pulse_interval_count == 8'hFF); // [R08]
	// a tick landing on the edge already belongs to the next interval
	assign cnt_start  = tick_ok ? 8'h01 : 8'h00;

	// register side strobes
	assign ctrl_wr    = wr_go && st_reg.w_strb[0] && (st_reg.aw_addr == ADDR_TACH_CTRL_STATUS);
	assign wrap_clr   = ctrl_wr && wb[BIT_WRAP]; // [R09] [R14]
	assign slow_clr   = ctrl_wr && wb[BIT_SLOW_FAN]; // [R14]
	assign reading_rd = rd_go && (axi_req.araddr == ADDR_INTERVAL_READING); // [R05]

	always_comb begin
		rd_byte = 8'h00;
		rd_resp = RESP_OKAY;
		case (axi_req.araddr)
			ADDR_INTERVAL_LIMIT:   rd_byte = st_reg.interval_limit;
			ADDR_INTERVAL_READING: rd_byte = st_reg.interval_reading;
			ADDR_TACH_CTRL_STATUS: begin
				rd_byte[BIT_NEW_READING]  = st_reg.ctrl.new_reading; // [R01]
				rd_byte[BIT_SLOW_FAN]     = st_reg.ctrl.slow_fan;
				rd_byte[BIT_WRAP]         = st_reg.ctrl.wrap;
				rd_byte[BIT_ALERT_EN]     = st_reg.ctrl.alert_en;
				rd_byte[BIT_FILTER_BYP]   = st_reg.ctrl.filter_bypass;
				rd_byte[BIT_RATE_LO +: 2] = st_reg.ctrl.count_rate;
			end
			ADDR_MONITOR_ENABLE:   rd_byte = {7'h00, st_reg.ctrl.enable};
			default:               rd_resp = RESP_SLVERR;
		endcase
	end

	always_comb begin
		case (st_reg.aw_addr)
			ADDR_INTERVAL_LIMIT, ADDR_INTERVAL_READING,
			ADDR_TACH_CTRL_STATUS, ADDR_MONITOR_ENABLE: wr_resp = RESP_OKAY;
			default:                                    wr_resp = RESP_SLVERR;
		endcase
	end

	always_comb begin
		st_next           = st_reg;
		st_next.tach_prev = tach_use_q;
		st_next.rate_prev = rate_lvl;
		st_next.flt_prev  = c32_q;

		// write address and data captured in either order
		st_next.rsp.awready = !st_reg.aw_held;
		st_next.rsp.wready  = !st_reg.w_held;
		if (axi_req.awvalid && st_reg.rsp.awready) begin
			st_next.aw_held     = 1'b1;
			st_next.aw_addr     = axi_req.awaddr;
			st_next.rsp.awready = 1'b0;
		end
		if (axi_req.wvalid && st_reg.rsp.wready) begin
			st_next.w_held     = 1'b1;
			st_next.w_data     = axi_req.wdata;
			st_next.w_strb     = axi_req.wstrb;
			st_next.rsp.wready = 1'b0;
		end
		if (st_reg.rsp.bvalid && axi_req.bready) begin
			st_next.rsp.bvalid = 1'b0;
			st_next.aw_held    = 1'b0;
			st_next.w_held     = 1'b0;
		end

		// measurement
		if (!st_reg.ctrl.enable) begin
			st_next.pulse_interval_count = 8'h00; // [R02]
			st_next.interval_reading     = 8'h00; // [R02]
			st_next.edges_seen           = 1'b0;
		end else if (edge_ok) begin
			st_next.edges_seen           = 1'b1;
			st_next.pulse_interval_count = cnt_start; // [R04]
			if (load_ok) begin
				st_next.interval_reading = st_reg.pulse_interval_count; // [R04]
				st_next.ctrl.new_reading = 1'b1; // [R04]
				if (over_limit) begin
					st_next.ctrl.slow_fan = 1'b1; // [R06]
				end
			end
		end else if (wrap_hit) begin
			st_next.ctrl.wrap            = 1'b1; // [R08]
			st_next.interval_reading     = 8'h00; // [R08]
			st_next.ctrl.new_reading     = 1'b0; // [R18]
			st_next.pulse_interval_count = 8'h00; // [R20]
		end else if (tick_ok) begin
			st_next.pulse_interval_count = st_reg.pulse_interval_count + 8'h01; // [R03]
		end

		// register writes; hardware sets above win over clears
		if (wr_go) begin
			st_next.rsp.bvalid = 1'b1;
			st_next.rsp.bresp  = wr_resp;
			if (st_reg.w_strb[0]) begin
				case (st_reg.aw_addr)
					ADDR_INTERVAL_LIMIT: st_next.interval_limit = wb; // [R12]
					ADDR_TACH_CTRL_STATUS: begin
						st_next.ctrl.count_rate    = wb[BIT_RATE_LO +: 2];
						st_next.ctrl.filter_bypass = wb[BIT_FILTER_BYP];
						st_next.ctrl.alert_en      = wb[BIT_ALERT_EN]; // [R17]
					end
					ADDR_MONITOR_ENABLE: st_next.ctrl.enable = wb[0];
					default: ;
				endcase
			end
		end
		if (wrap_clr && !wrap_hit) begin
			st_next.ctrl.wrap = 1'b0; // [R09] [R14]
		end
		if (slow_clr && !(load_ok && over_limit)) begin
			st_next.ctrl.slow_fan = 1'b0; // [R14]
			st_next.read_pending  = st_reg.ctrl.slow_fan || st_reg.read_pending; // [R07]
		end

		// reads
		if (st_reg.rsp.rvalid && axi_req.rready) begin
			st_next.rsp.rvalid = 1'b0;
		end
		st_next.rsp.arready = !st_next.rsp.rvalid && !rd_go;
		if (rd_go) begin
			st_next.rsp.rvalid  = 1'b1;
			st_next.rsp.rdata   = {24'h000000, rd_byte};
			st_next.rsp.rresp   = rd_resp;
			st_next.rsp.arready = 1'b0;
		end
		if (reading_rd) begin
			if (!load_ok) begin
				st_next.ctrl.new_reading = 1'b0; // [R05]
			end
			if (!st_next.ctrl.slow_fan) begin
				st_next.read_pending = 1'b0; // [R07]
			end
		end

		st_next.alert = st_next.ctrl.alert_en
			&& (st_next.ctrl.slow_fan || st_next.ctrl.wrap); // [R17] [R06] [R08]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg                 <= '0;
			st_reg.interval_limit  <= RST_INTERVAL_LIMIT; // [R12]
			st_reg.ctrl.count_rate <= RST_COUNT_RATE; // [R15]
		end else begin
			st_reg <= st_next;
		end
	end

	assign axi_rsp = st_reg.rsp;
	assign alert   = st_reg.alert;
endmodule : fan_tach_period_monitor

// file: tach_monitor.sv
`timescale 1ns/1ps
module tach_monitor (
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// bus and alert
	input wire tach_pkg::axi_req_s axi_req,
	input wire tach_pkg::axi_rsp_s axi_rsp,
	input wire logic              alert
);
	import tach_pkg::*;
	logic [3:0] ar_reg;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (axi_req.arvalid && axi_rsp.arready) begin
			ar_reg <= axi_req.araddr;
		end
	end
	a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read not answered");
	a_read_holds: assert property (axi_rsp.rvalid && !axi_req.rready
		|=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
	a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
		&& axi_rsp.wready |-> ##[1:3] axi_rsp.bvalid) else $error("write not answered");
	a_write_holds: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
		else $error("write response dropped");
	a_upper_zero: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_map_resp: assert property (axi_rsp.rvalid |->
		axi_rsp.rresp == ((ar_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR)) else $error("bad rresp");
	a_bit7_zero: assert property (axi_rsp.rvalid && ar_reg == ADDR_TACH_CTRL_STATUS
		|-> !axi_rsp.rdata[7]) else $error("reserved bit set");
	a_ready_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("read accepted while busy");
	a_alert_reset: assert property ($rose(aresetn) |-> !alert) else $error("alert after reset");
	c_read: cover property (axi_rsp.rvalid && axi_req.rready);
	c_write: cover property (axi_rsp.bvalid && axi_req.bready);
	c_alert: cover property ($rose(alert));
endmodule : tach_monitor
bind fan_tach_period_monitor tach_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .alert(alert));

// file: fan_tach_model.sv
`timescale 1ns/1ps
module fan_tach_model (
	// clock
	input wire logic        aclk,
	// pulse period and high width in clock cycles, period 0 = stopped fan
	input wire logic [15:0] period,
	input wire logic [15:0] width,
	// tach pulse to the monitor
	output logic            tach
);
	logic [15:0] cnt_reg = 16'h0000;
	always @(posedge aclk) begin
		cnt_reg <= (cnt_reg + 16'h0001 >= period) ? 16'h0000 : cnt_reg + 16'h0001;
	end
	assign tach = (period != 16'h0000) && (cnt_reg < width);
endmodule : fan_tach_model

// file: fan_tach_period_monitor_tb.sv
`timescale 1ns/1ps
module fan_tach_period_monitor_tb;
	import tach_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [5:0]  dv = 6'h00;
	axi_req_s    req = '0;
	axi_rsp_s    rsp;
	logic        alert, tach;
	logic [15:0] per = 16'h0000, wid = 16'h0014;
	logic [31:0] rdat;
	logic [1:0]  rrsp;
	logic [1:0]  brsp;
	int          n_errors = 0, n_checks = 0, cyc = 0;
	localparam logic [3:0] CS = ADDR_TACH_CTRL_STATUS, RD = ADDR_INTERVAL_READING;
	localparam logic [3:0] EN = ADDR_MONITOR_ENABLE;
	always #20 aclk = ~aclk;
	always @(posedge aclk) dv <= dv + 6'h01;
	fan_tach_period_monitor dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.clk_16k(dv[2]), .clk_8k(dv[3]), .clk_4k(dv[4]), .clk_2k(dv[5]), .clk_32k(dv[1]),
		.tach_pulse_in(tach), .alert(alert));
	fan_tach_model fan (.aclk(aclk), .period(per), .width(wid), .tach(tach));
	task automatic close_out;
		if (n_errors == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge aclk);
		req.awaddr <= a; req.awvalid <= 1'b1; req.wdata <= {24'h000000, d};
		req.wstrb <= 4'hF; req.wvalid <= 1'b1; req.bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				brsp = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rdat = rsp.rdata; rrsp = rsp.rresp; req.rready <= 1'b0;
				break;
			end
		end
	endtask : rd
	task automatic wait_n(input int n);
		repeat (n) @(posedge aclk);
	endtask : wait_n
	initial begin
		wait_n(6);
		aresetn <= 1'b1;
		rd(ADDR_INTERVAL_LIMIT); chk(rdat, 32'h000000FF);
		rd(RD); chk(rdat, 32'h00000000);
		rd(CS); chk(rdat, 32'h00000020);
		rd(4'h2); chk(32'(rrsp), 32'(RESP_SLVERR));
		wr(4'h2, 8'h55); chk(32'(brsp), 32'(RESP_SLVERR));
		rd(ADDR_INTERVAL_LIMIT); chk(rdat, 32'h000000FF);
		for (int r = 3; r >= 0; r--) begin
			wr(EN, 8'h00); wr(CS, 8'(r << 5) | 8'h10); wr(EN, 8'h01);
			per <= 16'd256; wait_n(1200); per <= 16'h0000; wait_n(300);
			rd(CS); chk(rdat, 32'(r << 5) | 32'h11);
			rd(RD); chk(rdat, 32'(32 >> r));
			rd(CS); chk(rdat, 32'(r << 5) | 32'h10);
		end
		wr(EN, 8'h00); wr(CS, 8'h18); wr(EN, 8'h01);
		per <= 16'd160; wait_n(800); rd(RD); chk(rdat, 32'h14);
		per <= 16'h0000; wait_n(2400);
		rd(CS); chk(rdat, 32'h1C);
		chk(32'(alert), 32'h1);
		rd(RD); chk(rdat, 32'h00);
		wr(CS, 8'h1C); rd(CS); chk(rdat, 32'h18);
		chk(32'(alert), 32'h0);
		per <= 16'd160; wait_n(800); rd(RD); chk(rdat, 32'h14);
		wr(EN, 8'h00); rd(RD); chk(rdat, 32'h00);
		wr(ADDR_INTERVAL_LIMIT, 8'h10); wr(EN, 8'h01); wait_n(800);
		chk(32'(brsp), 32'(RESP_OKAY));
		rd(EN); chk(rdat, 32'h01);
		rd(CS); chk(rdat, 32'h1B);
		chk(32'(alert), 32'h1);
		rd(RD); chk(rdat, 32'h14);
		per <= 16'd96; wait_n(400); rd(RD); chk(rdat, 32'h14);
		wr(CS, 8'h1A); rd(CS); chk(rdat & 32'h2, 32'h0);
		rd(RD); wait_n(400); rd(CS); chk(rdat & 32'h1, 32'h1);
		wr(EN, 8'h00); wr(ADDR_INTERVAL_LIMIT, 8'hFF); wr(CS, 8'h00); wr(EN, 8'h01);
		per <= 16'd256; wait_n(2600); rd(CS); chk(rdat, 32'h04);
		wid <= 16'd128; wr(CS, 8'h04); wait_n(1200);
		rd(RD); chk(rdat, 32'h20);
		close_out();
	end
endmodule : fan_tach_period_monitor_tb
